// ### mam_alarm_manager.sv
// Added by the designer: the plain strobed port and the register addresses.
`include "mam_params.svh"
// Operation
// - Nine input levels and eight output levels are each set separately.
// - A set level picks which pin state counts as asserted.
// - Any alarm stops motion; some alarms also cut motor current.
// - On alarm the indicator blinks and assigned alarm output goes active.
// - Alarm type is shown as a repeating count of blinks per cycle.
// - The active alarm code is held and returned on query.
// - Clear command clears clearable codes; system reset clears others too.
// - Serious internal faults are permanent; no command removes them.
// - Target position outside signed 32-bit milli-units raises code 32h.
// - Sequence stack exhaustion raises code 90h.
// - Calling a missing sequence as subroutine raises code 94h.
// - Arithmetic result past numeric limits raises code 98h.
// - Parameter assignment out of range raises code 99h.
// - Division by zero raises code 9Ah, clearable by clear command.
module mam_alarm_manager #(
    parameter int          POS_W     = `MAM_POS_W,
    parameter int          GEN_IN_N  = `MAM_GEN_IN_N,
    parameter int unsigned ON_CYC    = `MAM_BLINK_ON_CYC,
    parameter int unsigned GAP_CYC   = `MAM_BLINK_GAP_CYC
) (
    input  wire logic               i_clk,
    input  wire logic               i_sys_rst,
    input  wire logic               i_clk_en,
    input  wire logic [7:0]         i_addr,
    input  wire logic [31:0]        i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic      [31:0]        o_rdata,
    input  wire mam_pkg::mam_fault_t i_fault,
    input  wire logic [POS_W-1:0]   i_target_pos,
    input  wire logic               i_target_pos_valid,
    input  wire mam_pkg::mam_stat_t i_stat,
    input  wire logic [GEN_IN_N-1:0] i_gen_in_pins,
    output logic      [GEN_IN_N-1:0] o_gen_in_asserted,
    output logic      [7:0]         o_out_pins,
    output logic                    o_stop_motion,
    output logic                    o_current_off,
    output logic                    o_alarm_led,
    output logic                    o_irq
);
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (POS_W < 33 || POS_W > 64) begin : g_bad_pos
        $error("POS_W must be 33 to 64");
    end
    if (GEN_IN_N < 1 || GEN_IN_N > 16) begin : g_bad_in
        $error("GEN_IN_N must be 1 to 16");
    end
    if (ON_CYC < 1 || GAP_CYC < 1) begin : g_bad_cyc
        $error("Blink counts must be at least one");
    end

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Fixed priority when several faults land together
    function automatic logic [7:0] mam_code_of(
        input mam_pkg::mam_fault_t f,
        input logic                pos_bad
    );
        logic [7:0] c;
        c = `MAM_CODE_DIV0;
        if (f.internal)           c = `MAM_CODE_INTERN;
        else if (pos_bad)         c = `MAM_CODE_POS;
        else if (f.stack_overflow) c = `MAM_CODE_STACK;
        else if (f.call_missing)  c = `MAM_CODE_CALL;
        else if (f.calc_overflow) c = `MAM_CODE_CALC;
        else if (f.param_range)   c = `MAM_CODE_PARAM;
        return c;
    endfunction : mam_code_of

    // Zero would never show; treat as one blink
    function automatic logic [3:0] mam_blinks(
        input logic [7:0] code,
        input logic [7:0] cfg
    );
        logic [3:0] n;
        n = (code == `MAM_CODE_INTERN) ? cfg[7:4] : cfg[3:0];
        return (n == 4'h0) ? 4'h1 : n;
    endfunction : mam_blinks

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [2:0]  ctrl;
    logic [23:0] level;
    logic [7:0]  blink_cfg;
    logic [2:0]  irq_st;
    logic [2:0]  irq_msk;
    logic        alarm_active;
    logic [7:0]  alarm_code;

    // Bus decode
    wire wr_ctrl  = i_wr && (i_addr == `MAM_REG_CTRL);
    wire wr_level = i_wr && (i_addr == `MAM_REG_LEVEL);
    wire wr_ist   = i_wr && (i_addr == `MAM_REG_IRQ_ST);
    wire wr_imsk  = i_wr && (i_addr == `MAM_REG_IRQ_MSK);
    wire wr_blink = i_wr && (i_addr == `MAM_REG_BLINK);
    wire clr_cmd  = wr_ctrl && i_wdata[`MAM_CTRL_CLR];
    wire rst_cmd  = wr_ctrl && i_wdata[`MAM_CTRL_SYSRST];

    // ----------------------------------------
    // Fault detection and latch
    // ----------------------------------------
    // Upper bits must all copy bit 31 to fit signed 32 bits
    wire [POS_W-32:0] pos_top = i_target_pos[POS_W-1:31];
    wire pos_bad   = i_target_pos_valid && !(&pos_top || !(|pos_top));
    wire fault_any = (|i_fault) || pos_bad;
    wire [7:0] new_code = mam_code_of(i_fault, pos_bad);

    wire perm      = (alarm_code == `MAM_CODE_INTERN);
    wire clearable = (alarm_code == `MAM_CODE_DIV0);
    // Permanent faults ignore both commands
    wire clear_ok  = alarm_active && !perm
                   && (rst_cmd || (clr_cmd && clearable));
    wire refused   = alarm_active && clr_cmd && !clear_ok;
    wire hold      = alarm_active && !clear_ok;
    // New fault in the clearing cycle still latches
    wire       next_active = hold || fault_any;
    wire [7:0] next_code   = hold ? alarm_code :
                             (fault_any ? new_code : 8'h00);

    // Latched alarm; only power-up reset drops a permanent one
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            alarm_active <= 1'b0;
            alarm_code   <= 8'h00;
        end else if (i_clk_en) begin
            alarm_active <= next_active;
            alarm_code   <= next_code;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    wire [2:0] next_ctrl  = wr_ctrl ? {i_wdata[`MAM_CTRL_ASGN], 2'b00} : ctrl;
    wire [23:0] next_level = wr_level ? i_wdata[23:0] : level;

    // Command bits are pulses and never stored
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl      <= `MAM_CTRL_RSTV;
            level     <= `MAM_LEVEL_RSTV;
            blink_cfg <= `MAM_BLINK_RSTV;
            irq_msk   <= 3'h0;
        end else if (i_clk_en) begin
            ctrl      <= next_ctrl;
            level     <= next_level;
            blink_cfg <= wr_blink ? i_wdata[7:0] : blink_cfg;
            irq_msk   <= wr_imsk ? i_wdata[2:0] : irq_msk;
        end
    end

    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    wire [2:0] irq_ev;
    assign irq_ev[`MAM_IRQ_RAISE]  = fault_any && !hold;
    assign irq_ev[`MAM_IRQ_CLEAR]  = clear_ok;
    assign irq_ev[`MAM_IRQ_REFUSE] = refused;
    wire [2:0] w1c         = wr_ist ? i_wdata[2:0] : 3'h0;
    // Set beats write-one-clear in the same cycle
    wire [2:0] next_irq_st = (irq_st & ~w1c) | irq_ev;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_st <= 3'h0;
            o_irq  <= 1'b0;
        end else if (i_clk_en) begin
            irq_st <= next_irq_st;
            o_irq  <= |(next_irq_st & irq_msk);
        end
    end

    // ----------------------------------------
    // Alarm indicator blink sequence
    // ----------------------------------------
    mam_pkg::mam_blink_t bl_state;
    mam_pkg::mam_blink_t next_bl_state;
    logic [31:0] bl_cyc;
    logic [3:0]  bl_left;
    logic [31:0] next_bl_cyc;
    logic [3:0]  next_bl_left;
    wire on_end  = (bl_cyc == 32'(ON_CYC - 1));
    wire gap_end = (bl_cyc == 32'(GAP_CYC - 1));
    wire [3:0] bl_n = mam_blinks(alarm_code, blink_cfg);

    // On and off phases per blink, then a long gap, repeating
    always_comb begin
        next_bl_state = bl_state;
        next_bl_cyc   = bl_cyc + 32'h1;
        next_bl_left  = bl_left;
        case (bl_state)
            mam_pkg::MAM_BL_IDLE: begin
                next_bl_cyc = 32'h0;
                if (alarm_active) begin
                    next_bl_state = mam_pkg::MAM_BL_ON;
                    next_bl_left  = bl_n;
                end
            end
            mam_pkg::MAM_BL_ON: begin
                if (on_end) begin
                    next_bl_state = mam_pkg::MAM_BL_OFF;
                    next_bl_cyc   = 32'h0;
                end
            end
            mam_pkg::MAM_BL_OFF: begin
                if (on_end) begin
                    next_bl_cyc  = 32'h0;
                    next_bl_left = bl_left - 4'h1;
                    next_bl_state = (bl_left == 4'h1) ?
                        mam_pkg::MAM_BL_GAP : mam_pkg::MAM_BL_ON;
                end
            end
            mam_pkg::MAM_BL_GAP: begin
                if (gap_end) begin
                    next_bl_state = mam_pkg::MAM_BL_ON;
                    next_bl_cyc   = 32'h0;
                    next_bl_left  = bl_n;
                end
            end
            default: begin
                next_bl_state = mam_pkg::MAM_BL_IDLE;
            end
        endcase
        // Clearing the alarm stops the indicator at once
        if (!alarm_active) begin
            next_bl_state = mam_pkg::MAM_BL_IDLE;
            next_bl_cyc   = 32'h0;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bl_state    <= mam_pkg::MAM_BL_IDLE;
            bl_cyc      <= 32'h0;
            bl_left     <= 4'h0;
            o_alarm_led <= 1'b0;
        end else if (i_clk_en) begin
            bl_state    <= next_bl_state;
            bl_cyc      <= next_bl_cyc;
            bl_left     <= next_bl_left;
            o_alarm_led <= (next_bl_state == mam_pkg::MAM_BL_ON);
        end
    end

    // ----------------------------------------
    // Pin levels and protective outputs
    // ----------------------------------------
    // Level 1 means the pin is low when asserted
    wire [GEN_IN_N-1:0] next_in_asrt = i_gen_in_pins ^ level[GEN_IN_N-1:0];
    // Unassigned alarm output rests at its inactive level
    wire alarm_sig = alarm_active && ctrl[`MAM_CTRL_ASGN];
    wire [7:0] next_out_pins = {i_stat, alarm_sig}
                             ^ level[`MAM_LVL_OUT_LSB +: 8];
    wire next_cur_off = next_active && (next_code == `MAM_CODE_INTERN);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_gen_in_asserted <= '0;
            o_out_pins        <= 8'h00;
            o_stop_motion     <= 1'b0;
            o_current_off     <= 1'b0;
        end else if (i_clk_en) begin
            o_gen_in_asserted <= next_in_asrt;
            o_out_pins        <= next_out_pins;
            o_stop_motion     <= next_active;
            o_current_off     <= next_cur_off;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    wire [31:0] alarm_word = {20'h0, perm && alarm_active, clearable && alarm_active,
                              o_current_off, alarm_active, alarm_code};
    wire [31:0] rd_mux =
        (i_addr == `MAM_REG_CTRL)    ? {29'h0, ctrl} :
        (i_addr == `MAM_REG_LEVEL)   ? {8'h0, level} :
        (i_addr == `MAM_REG_ALARM)   ? alarm_word :
        (i_addr == `MAM_REG_IRQ_ST)  ? {29'h0, irq_st} :
        (i_addr == `MAM_REG_IRQ_MSK) ? {29'h0, irq_msk} :
        (i_addr == `MAM_REG_INPUTS)  ? 32'(o_gen_in_asserted) :
        (i_addr == `MAM_REG_BLINK)   ? {24'h0, blink_cfg} : 32'h0;

    // Data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 32'h0;
        end else if (i_clk_en) begin
            o_rdata <= i_rd ? rd_mux : 32'h0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    property p_latch_hold;
        i_clk_en && alarm_active && !clear_ok |=> $stable(alarm_code) && alarm_active;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("Latched code changed");

    property p_stop;
        i_clk_en && !alarm_active && fault_any |=> o_stop_motion && alarm_active;
    endproperty
    a_stop: assert property (p_stop) else $error("Fault did not stop motion");

    property p_perm;
        i_clk_en && alarm_active && alarm_code == `MAM_CODE_INTERN
            |=> alarm_active && o_current_off;
    endproperty
    a_perm: assert property (p_perm) else $error("Permanent alarm lost");

    property p_div_clear;
        i_clk_en && alarm_active && alarm_code == `MAM_CODE_DIV0 && clr_cmd && !fault_any
            |=> !alarm_active ##1 !o_stop_motion;
    endproperty
    a_div_clear: assert property (p_div_clear) else $error("Zero division not cleared");

    property p_refuse;
        i_clk_en && alarm_active && alarm_code != `MAM_CODE_DIV0 && clr_cmd && !rst_cmd
            |=> alarm_active && irq_st[`MAM_IRQ_REFUSE];
    endproperty
    a_refuse: assert property (p_refuse) else $error("Clear removed a fixed alarm");

    property p_pos;
        i_clk_en && !alarm_active && pos_bad && !i_fault.internal
            |=> alarm_code == `MAM_CODE_POS;
    endproperty
    a_pos: assert property (p_pos) else $error("Position range code wrong");

    property p_led;
        i_clk_en && $rose(alarm_active) |=> o_alarm_led;
    endproperty
    a_led: assert property (p_led) else $error("Indicator did not start");

    wire [GEN_IN_N-1:0] in_lvl = level[GEN_IN_N-1:0];
    property p_in_level;
        i_clk_en |=> o_gen_in_asserted == ($past(i_gen_in_pins) ^ $past(in_lvl));
    endproperty
    a_in_level: assert property (p_in_level) else $error("Input level wrong");

    property p_query;
        i_clk_en && i_rd && i_addr == `MAM_REG_ALARM
            |=> o_rdata[7:0] == $past(alarm_code);
    endproperty
    a_query: assert property (p_query) else $error("Query code wrong");

    c_div_clear: cover property (alarm_active && clearable && clr_cmd ##1 !alarm_active);
    c_refused:   cover property (refused);
    c_sys_clear: cover property (alarm_active && !clearable && rst_cmd && !perm);
    c_gap:       cover property (bl_state == mam_pkg::MAM_BL_GAP);
endmodule : mam_alarm_manager

// ### mam_params.svh
`ifndef MAM_PARAMS_SVH
`define MAM_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MAM_REG_CTRL    8'h00
`define MAM_REG_LEVEL   8'h04
`define MAM_REG_ALARM   8'h08
`define MAM_REG_IRQ_ST  8'h0c
`define MAM_REG_IRQ_MSK 8'h10
`define MAM_REG_INPUTS  8'h14
`define MAM_REG_BLINK   8'h18
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MAM_CTRL_CLR    0
`define MAM_CTRL_SYSRST 1
`define MAM_CTRL_ASGN   2
`define MAM_LVL_OUT_LSB 16
`define MAM_IRQ_RAISE   0
`define MAM_IRQ_CLEAR   1
`define MAM_IRQ_REFUSE  2
`define MAM_ALM_ACT     8
`define MAM_ALM_CUR     9
`define MAM_ALM_CLRBL   10
`define MAM_ALM_PERM    11
// ----------------------------------------
// Alarm codes
// ----------------------------------------
`define MAM_CODE_POS    8'h32
`define MAM_CODE_STACK  8'h90
`define MAM_CODE_CALL   8'h94
`define MAM_CODE_CALC   8'h98
`define MAM_CODE_PARAM  8'h99
`define MAM_CODE_DIV0   8'h9a
`define MAM_CODE_INTERN 8'hf0
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define MAM_CTRL_RSTV   3'h4
`define MAM_LEVEL_RSTV  24'h000000
`define MAM_BLINK_RSTV  8'h21
`define MAM_POS_W       48
`define MAM_GEN_IN_N    9
`define MAM_CLK_MHZ     100
`define MAM_BLINK_ON_MS 200
`define MAM_BLINK_GAP_MS 1200
`define MAM_BLINK_ON_CYC (`MAM_BLINK_ON_MS * 1000 * `MAM_CLK_MHZ)
`define MAM_BLINK_GAP_CYC (`MAM_BLINK_GAP_MS * 1000 * `MAM_CLK_MHZ)
`endif

// ### mam_pkg.sv
package mam_pkg;
    // ----------------------------------------
    // Fault event and status carriers
    // ----------------------------------------
    typedef struct packed {
        logic internal;
        logic div_zero;
        logic param_range;
        logic calc_overflow;
        logic call_missing;
        logic stack_overflow;
    } mam_fault_t;

    typedef struct packed {
        logic seq_running;
        logic ready;
        logic paused;
        logic moving;
        logic limiting;
        logic home_pos;
        logic motion_done;
    } mam_stat_t;

    typedef enum logic [1:0] {
        MAM_BL_IDLE,
        MAM_BL_ON,
        MAM_BL_OFF,
        MAM_BL_GAP
    } mam_blink_t;
endpackage : mam_pkg

// ### mam_motion_model.sv
// ----------------------------------------
// Far-side motion and sequence engine
// ----------------------------------------
module mam_motion_model #(
    parameter int DECEL_CYC = 6
) (
    input  wire logic                i_clk,
    input  wire logic                i_go,
    input  wire logic [2:0]          i_kind,
    input  wire logic [47:0]         i_pos,
    output mam_pkg::mam_fault_t      o_fault,
    output logic                     o_pos_valid,
    output logic      [47:0]         o_pos,
    output logic                     o_settled
);
    timeunit 1ns;
    timeprecision 1ps;
    int                   decel_cnt   = DECEL_CYC;
    mam_pkg::mam_fault_t  fault_q     = '0;
    logic                 pos_valid_q = 1'b0;
    logic      [47:0]     pos_q       = 48'h0;

    // One-cycle fault event; kinds 0..5 map to fault bits, 6 is a position
    always @(posedge i_clk) begin
        if (i_go && i_kind < 3'h6) begin
            fault_q <= mam_pkg::mam_fault_t'(6'h1 << i_kind);
        end else begin
            fault_q <= '0;
        end
        pos_valid_q <= i_go && (i_kind == 3'h6);
        // Unqualified position toggles so a stale value is never trusted
        pos_q <= (i_go && i_kind == 3'h6) ? i_pos : ~pos_q;
    end
    assign o_fault     = fault_q;
    assign o_pos_valid = pos_valid_q;
    assign o_pos       = pos_q;

    // Clearing early could restart the axis, so wait out the ramp down
    always @(posedge i_clk) begin
        decel_cnt <= i_go ? 0 : (decel_cnt < DECEL_CYC ? decel_cnt + 1 : decel_cnt);
    end
    assign o_settled = (decel_cnt == DECEL_CYC);
endmodule : mam_motion_model

// ### motion_alarm_manager_bench.sv
`include "mam_params.svh"
module motion_alarm_manager_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 i_clk = 1'b0;
    logic                 i_sys_rst = 1'b1;
    logic                 i_wr = 1'b0;
    logic                 i_rd = 1'b0;
    logic                 go = 1'b0;
    logic [7:0]           i_addr = 8'h0;
    logic [31:0]          i_wdata = 32'h0;
    logic [31:0]          o_rdata;
    logic [2:0]           kind = 3'h0;
    logic [47:0]          pos = 48'h0;
    logic [8:0]           pins = 9'h0ff;
    logic [8:0]           o_gen_in_asserted;
    logic [7:0]           o_out_pins;
    logic                 o_stop_motion, o_current_off, o_alarm_led, o_irq, settled, pos_valid;
    logic [47:0]          tgt;
    mam_pkg::mam_fault_t  flt;
    mam_pkg::mam_stat_t   i_stat = 7'h55;
    int                   num_errors = 0;
    int                   tests_run = 0;
    int                   cycles = 0;
    logic [7:0]           codes [7] = '{`MAM_CODE_STACK, `MAM_CODE_CALL, `MAM_CODE_CALC, `MAM_CODE_PARAM,
                                        `MAM_CODE_DIV0, `MAM_CODE_POS, `MAM_CODE_POS};
    logic [2:0]           kinds [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h6};
    logic [47:0]          poses [7] = '{48'h0, 48'h0, 48'h0, 48'h0, 48'h0, 48'h0000_8000_0000, 48'hffff_7fff_ffff};

    always #5 i_clk = ~i_clk;

    mam_alarm_manager #(.ON_CYC(4), .GAP_CYC(10)) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fault(flt), .i_target_pos(tgt),
        .i_target_pos_valid(pos_valid), .i_stat(i_stat), .i_gen_in_pins(pins),
        .o_gen_in_asserted(o_gen_in_asserted), .o_out_pins(o_out_pins), .o_stop_motion(o_stop_motion),
        .o_current_off(o_current_off), .o_alarm_led(o_alarm_led), .o_irq(o_irq)
    );

    mam_motion_model partner (
        .i_clk(i_clk), .i_go(go), .i_kind(kind), .i_pos(pos), .o_fault(flt),
        .o_pos_valid(pos_valid), .o_pos(tgt), .o_settled(settled)
    );

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(nm, exp, o_rdata);
    endtask : rd

    // Fault request, then bounded wait for the axis to come to rest
    task automatic fault(input logic [2:0] k, input logic [47:0] p);
        @(posedge i_clk);
        go <= 1'b1;
        kind <= k;
        pos <= p;
        @(posedge i_clk);
        go <= 1'b0;
        // Let the ramp-down counter restart before polling it
        #1;
        for (int n = 0; n < 40 && !(settled === 1'b1); n++) @(posedge i_clk);
        repeat (2) @(posedge i_clk);
        #1;
    endtask : fault

    task automatic count_blinks(input int win, input int exp);
        int   rises;
        logic prev;
        rises = 0;
        prev = o_alarm_led;
        repeat (win) begin
            @(posedge i_clk);
            #1;
            if (o_alarm_led === 1'b1 && prev === 1'b0) rises++;
            prev = o_alarm_led;
        end
        chk("blink count", exp, rises);
    endtask : count_blinks

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    // Hang guard, far above the expected run length
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            finish_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(`MAM_REG_CTRL, 32'h4, "ctrl reset");
        rd(`MAM_REG_LEVEL, 32'h0, "level reset");
        rd(`MAM_REG_BLINK, 32'h21, "blink reset");
        rd(8'h1c, 32'h0, "unmapped");
        // Separate input and output levels
        wr(`MAM_REG_LEVEL, 32'h000e_01a5);
        repeat (3) @(posedge i_clk);
        rd(`MAM_REG_INPUTS, 32'h0000_015a, "inputs");
        chk("out pins", {24'h0, 8'haa ^ 8'h0e}, {24'h0, o_out_pins});
        wr(`MAM_REG_IRQ_MSK, 32'h1);
        wr(`MAM_REG_BLINK, 32'h23);
        // Every code except F0h, a boundary check on position and the lock on the latched code
        fault(3'h6, 48'h0000_7fff_ffff);
        fault(3'h6, 48'hffff_8000_0000);
        rd(`MAM_REG_ALARM, 32'h0, "in range");
        for (int i = 0; i < 7; i++) begin
            fault(kinds[i], poses[i]);
            chk("stop", 32'h1, {31'h0, o_stop_motion});
            chk("current", 32'h0, {31'h0, o_current_off});
            chk("alarm pin", 32'h1, {31'h0, o_out_pins[0]});
            chk("irq", 32'h1, {31'h0, o_irq});
            fault(i == 1 ? 3'h0 : 3'h1, 48'h0);
            rd(`MAM_REG_ALARM, {21'h0, codes[i] == 8'h9a, 2'b01, codes[i]}, "code");
            wr(`MAM_REG_CTRL, 32'h5);
            rd(`MAM_REG_ALARM, codes[i] == 8'h9a ? 32'h0 : {23'h0, 1'b1, codes[i]}, "clear cmd");
            rd(`MAM_REG_IRQ_ST, codes[i] == 8'h9a ? 32'h3 : 32'h5, "irq status");
            wr(`MAM_REG_CTRL, 32'h6);
            rd(`MAM_REG_ALARM, 32'h0, "system clear");
            wr(`MAM_REG_IRQ_ST, 32'h7);
            rd(`MAM_REG_IRQ_ST, 32'h0, "irq w1c");
            chk("irq low", 32'h0, {31'h0, o_irq});
        end
        // Blink pattern and its stop on clear
        fault(3'h4, 48'h0);
        count_blinks(28, 3);
        wr(`MAM_REG_CTRL, 32'h1);
        repeat (2) @(posedge i_clk);
        #1 chk("led off", 32'h0, {31'h0, o_alarm_led});
        wr(`MAM_REG_IRQ_MSK, 32'h0);
        // Internal fault: cuts current, survives both commands
        fault(3'h5, 48'h0);
        chk("current off", 32'h1, {31'h0, o_current_off});
        chk("unassigned pin", 32'h0, {31'h0, o_out_pins[0]});
        chk("masked irq", 32'h0, {31'h0, o_irq});
        count_blinks(22, 2);
        wr(`MAM_REG_CTRL, 32'h7);
        rd(`MAM_REG_ALARM, 32'h0bf0, "permanent");
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(`MAM_REG_ALARM, 32'h0, "power cycle");
        rd(`MAM_REG_CTRL, 32'h4, "ctrl after reset");
        finish_test();
    end
endmodule : motion_alarm_manager_bench
